// ---- hdl/dpll_phase_detector_range.sv ----
// APB-configured range control for the DPLL phase detector and loop phase error.
`timescale 1ns/10ps
// Functional notes
// - Wide range bit clear: wide detector off, tracking limited to one unit_interval.
// - Wide range bit set: wide phase detector on, multi-UI tracking for limit codes 1-15; the loss flag has its own enable bit.
// - Coarse bit clear: loop phase error clamped to plus or minus one unit_interval.
// - Coarse clear, wide set: tracked phase position still kept over many UI.
// - Coarse bit set: tracker result, up to 8191 UI with wide set and one UI with wide clear, feeds the loop.
// - Coarse result gives proportional pull-in; clamped error limits overshoot.
// - Coarse direct locking keeps multi-UI error, matching divided-input dynamics.
// - Four-bit limit code roughly doubles span from 1 UI; codes 12-15 give maximum.
module dpll_phase_detector_range
    import dpll_pd_pkg::*;
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Coarse phase measurement in
    input  wire ph_sample_t        ph_meas,
    // Loop and detector outputs
    output ph_sample_t             loop_err,
    output logic signed [PH_W-1:0] phase_pos,
    output logic                   wide_det_en,
    output logic                   phase_loss
);

    // Span of the coarse tracker for a limit code, in scaled phase units.
    function automatic logic signed [PH_W-1:0] span_of(input logic [3:0] code);
        logic [3:0]      c;
        logic [PH_W-1:0] ui_mask;
        c       = (code >= LIMIT_MAX) ? LIMIT_MAX : code;
        ui_mask = (PH_ONE << (c + 4'h1)) - PH_ONE;
        span_of = $signed(ui_mask << FRAC_W);
    endfunction

    // Symmetric saturation of a phase word to plus or minus lim.
    function automatic logic signed [PH_W-1:0] clamp(input logic signed [PH_W-1:0] v,
                                                     input logic signed [PH_W-1:0] lim);
        if (v > lim) begin
            clamp = lim;
        end else if (v < -lim) begin
            clamp = -lim;
        end else begin
            clamp = v;
        end
    endfunction

    cfg_t                   cfg_q;
    cfg_t                   cfg_d;
    logic [31:0]            prdata_q;
    logic                   pready_q;
    logic                   pslverr_q;
    ph_sample_t             loop_q;
    ph_sample_t             loop_d;
    logic signed [PH_W-1:0] pos_q;
    logic signed [PH_W-1:0] pos_d;
    logic                   wide_q;
    logic                   loss_q;
    logic                   loss_d;

    // Bus decode.
    wire                    setup    = psel & ~penable;
    wire                    done     = psel & penable & pready_q;
    wire                    hit_cfg  = (paddr == CFG_OFFSET);
    wire                    hit_stat = (paddr == STAT_OFFSET);
    wire                    wr_cfg   = done & pwrite & hit_cfg & pstrb[0];
    wire [7:0]              cfg_rd   = cfg_q & CFG_WMASK;
    wire [7:0]              stat_rd  = {6'h00, wide_q, loss_q};
    wire [31:0]             rd_sel   = hit_cfg  ? {24'h00_0000, cfg_rd} :
                                       hit_stat ? {24'h00_0000, stat_rd} : RD_ZERO;

    // Bit 4 is masked on every write, so it can never be stored.
    assign cfg_d = wr_cfg ? cfg_t'(pwdata[7:0] & CFG_WMASK) : cfg_q;

    // Tracker span: one unit_interval unless the wide range detector is on.
    wire signed [PH_W-1:0]  span_w   = cfg_q.wide ? span_of(cfg_q.limit) : ONE_UI;
    wire signed [PH_W-1:0]  track_w  = clamp(ph_meas.err, span_w);
    wire                    in_span  = (ph_meas.err <= span_w) && (ph_meas.err >= -span_w);

    // The loop sees either the linear coarse result or a one-UI clamp of it.
    // Linear feed gives pull-in proportional to error; the clamp trades speed for overshoot.
    wire signed [PH_W-1:0]  loop_w   = cfg_q.coarse_result_in_loop ? track_w
                                                                   : clamp(track_w, ONE_UI);

    // The phase position keeps the wide tracker value even when the loop is clamped.
    assign pos_d  = ph_meas.valid ? track_w : pos_q;
    assign loop_d = '{valid: ph_meas.valid, err: ph_meas.valid ? loop_w : loop_q.err};
    assign loss_d = ph_meas.valid ? (cfg_q.loss_en & ~in_span) : loss_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q     <= cfg_t'(CFG_RESET);
            prdata_q  <= RD_ZERO;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            cfg_q     <= cfg_d;
            prdata_q  <= setup ? rd_sel : prdata_q;
            pready_q  <= setup;
            pslverr_q <= setup & ~(hit_cfg | hit_stat);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_q <= '{valid: 1'b0, err: PH_ZERO};
            pos_q  <= PH_ZERO;
            wide_q <= 1'b0;
            loss_q <= 1'b0;
        end else begin
            loop_q <= loop_d;
            pos_q  <= pos_d;
            wide_q <= cfg_q.wide;
            loss_q <= loss_d;
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign loop_err    = loop_q;
    assign phase_pos   = pos_q;
    assign wide_det_en = wide_q;
    assign phase_loss  = loss_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Detector enable follows the stored wide range bit one cycle later.
    a_wide_det_follow: assert property (
        1'b1 |=> (wide_det_en == $past(cfg_q.wide)))
        else $error("wide detector enable does not follow config bit");

    a_narrow_pos_span: assert property (
        (ph_meas.valid && !cfg_q.wide) |=> (phase_pos <= ONE_UI && phase_pos >= -ONE_UI))
        else $error("phase position exceeds one UI with wide range off");

    a_loop_one_ui: assert property (
        (ph_meas.valid && !cfg_q.coarse_result_in_loop)
            |=> (loop_err.err <= ONE_UI && loop_err.err >= -ONE_UI))
        else $error("clamped loop error exceeds one UI");

    a_retain_position: assert property (
        (ph_meas.valid && !cfg_q.coarse_result_in_loop && cfg_q.wide && in_span)
            |=> (phase_pos == $past(ph_meas.err)))
        else $error("phase position lost while loop error clamped");

    a_full_range: assert property (
        (ph_meas.valid && cfg_q.coarse_result_in_loop && cfg_q.wide
            && cfg_q.limit >= LIMIT_MAX && ph_meas.err >= MAX_SPAN)
            |=> (loop_err.err == MAX_SPAN))
        else $error("coarse loop error does not reach 8191 UI");

    a_span_max_code: assert property (
        (ph_meas.valid && cfg_q.wide && cfg_q.limit >= LIMIT_MAX
            && ph_meas.err < -MAX_SPAN) |=> (phase_pos == -MAX_SPAN))
        else $error("maximum limit code does not saturate at 8191 UI");

    a_pull_in_linear: assert property (
        (ph_meas.valid && cfg_q.coarse_result_in_loop && in_span)
            |=> (loop_err.valid && loop_err.err == $past(ph_meas.err)))
        else $error("coarse loop error is not proportional to measurement");

    // Two back-to-back in-span samples must both reach the loop unclamped.
    sequence s_coarse_pair;
        (ph_meas.valid && cfg_q.coarse_result_in_loop && in_span)
            ##1 (ph_meas.valid && cfg_q.coarse_result_in_loop && in_span);
    endsequence

    a_direct_dynamics: assert property (
        s_coarse_pair |=> (loop_err.err == $past(ph_meas.err)
                           && $past(loop_err.err) == $past(ph_meas.err, 2)))
        else $error("coarse samples not passed through in sequence");

    a_unused_bit_zero: assert property (
        (pready && $past(setup && hit_cfg)) |-> (prdata[BIT_UNUSED] == 1'b0 && !cfg_q.unused))
        else $error("unused config bit reads nonzero");

    a_loss_flag: assert property (
        (ph_meas.valid && cfg_q.loss_en && !in_span) |=> phase_loss)
        else $error("phase loss not flagged outside tracker span");

endmodule

// ---- pkg/dpll_pd_pkg.sv ----
// Constants and carrier types for the DPLL phase detector range block.
package dpll_pd_pkg;

    // APB register map (byte addresses).
    localparam int           ADDR_W      = 8;
    localparam logic [7:0]   CFG_OFFSET  = 8'h74;
    localparam logic [7:0]   STAT_OFFSET = 8'h78;

    // Configuration register layout and value after reset.
    localparam logic [7:0]   CFG_RESET   = 8'h85;
    localparam logic [7:0]   CFG_WMASK   = 8'hEF;
    localparam int           BIT_LOSS_EN = 7;
    localparam int           BIT_WIDE    = 6;
    localparam int           BIT_COARSE  = 5;
    localparam int           BIT_UNUSED  = 4;
    localparam int           LIMIT_LSB   = 0;
    localparam logic [3:0]   LIMIT_MAX   = 4'hC;

    // Status register layout.
    localparam int           STAT_LOSS   = 0;
    localparam int           STAT_WIDE   = 1;

    // Phase words: signed, unit_interval scaled by 2**FRAC_W.
    localparam int           PH_W        = 24;
    localparam int           FRAC_W      = 8;
    localparam logic [23:0]  PH_ONE      = 24'h00_0001;
    localparam logic signed [23:0] ONE_UI   = 24'sh00_0100;
    localparam logic signed [23:0] MAX_SPAN = 24'sh1F_FF00;
    localparam logic signed [23:0] PH_ZERO  = 24'sh00_0000;
    localparam logic [31:0]  RD_ZERO     = 32'h0000_0000;

    typedef struct packed {
        logic       loss_en;
        logic       wide;
        logic       coarse_result_in_loop;
        logic       unused;
        logic [3:0] limit;
    } cfg_t;

    typedef struct packed {
        logic                   valid;
        logic signed [PH_W-1:0] err;
    } ph_sample_t;

endpackage

// ---- sim/tb.sv ----
// Self-checking bench for the DPLL phase detector range block.
`timescale 1ns/10ps
module tb
    import dpll_pd_pkg::*;
;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [31:0]       pwdata = '0;
    logic [3:0]        pstrb = '0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    ph_sample_t        ph_meas = '0;
    ph_sample_t        loop_err;
    logic signed [PH_W-1:0] phase_pos;
    logic              wide_det_en;
    logic              phase_loss;
    int                num_errors = 0;
    int                n_compared = 0;
    int                cyc = 0;
    logic [31:0]       rd;
    logic              er;

    dpll_phase_detector_range dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ph_meas(ph_meas), .loop_err(loop_err),
        .phase_pos(phase_pos), .wide_det_en(wide_det_en), .phase_loss(phase_loss));

    always #5 pclk = ~pclk;

    task automatic summarize();
        $display("Checks %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A stuck handshake would otherwise hang the run forever.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // The access ends at the rising edge where pready is seen high; data is taken at that edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Writes the configuration, sends one sample and checks the loop outputs.
    task automatic ph(input logic [7:0] c, input logic [23:0] e, input logic [23:0] lp,
                      input logic [23:0] pos, input logic loss);
        apb(1'b1, CFG_OFFSET, {24'h00_0000, c});
        @(posedge pclk);
        ph_meas <= '{valid: 1'b1, err: e};
        @(posedge pclk);
        ph_meas.valid <= 1'b0;
        @(negedge pclk);
        chk("loop_valid", {31'h0, loop_err.valid}, 32'h0000_0001);
        chk("loop_err", {8'h00, loop_err.err}, {8'h00, lp});
        chk("phase_pos", {8'h00, phase_pos}, {8'h00, pos});
        chk("phase_loss", {31'h0, phase_loss}, {31'h0, loss});
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CFG_OFFSET, '0);
        chk("cfg_reset", rd, 32'h0000_0085);
        apb(1'b1, CFG_OFFSET, 32'h0000_00FF);
        apb(1'b0, CFG_OFFSET, '0);
        chk("cfg_unused_bit", rd, 32'h0000_00EF);
        repeat (2) @(posedge pclk);
        chk("wide_on", {31'h0, wide_det_en}, 32'h0000_0001);
        apb(1'b1, 8'h40, 32'h0000_0000);
        chk("unmapped_err", {31'h0, er}, 32'h0000_0001);
        chk("unmapped_data", rd, 32'h0000_0000);
        ph(8'h05, 24'h00_0300, 24'h00_0100, 24'h00_0100, 1'b0);
        chk("wide_off", {31'h0, wide_det_en}, 32'h0000_0000);
        ph(8'h00, 24'hFF_FD00, 24'hFF_FF00, 24'hFF_FF00, 1'b0);
        ph(8'h45, 24'h00_0300, 24'h00_0100, 24'h00_0300, 1'b0);
        ph(8'h65, 24'h00_0300, 24'h00_0300, 24'h00_0300, 1'b0);
        ph(8'h61, 24'h00_0500, 24'h00_0300, 24'h00_0300, 1'b0);
        ph(8'h6C, 24'h7F_FFFF, 24'h1F_FF00, 24'h1F_FF00, 1'b0);
        ph(8'h6F, 24'h80_0000, 24'hE0_0100, 24'hE0_0100, 1'b0);
        @(posedge pclk);
        ph_meas <= '{valid: 1'b1, err: 24'h00_0200};
        @(posedge pclk);
        ph_meas <= '{valid: 1'b1, err: 24'hFF_FE00};
        @(negedge pclk);
        chk("pair_first", {8'h00, loop_err.err}, 32'h0000_0200);
        @(posedge pclk);
        ph_meas.valid <= 1'b0;
        @(negedge pclk);
        chk("pair_second", {8'h00, loop_err.err}, 32'h00FF_FE00);
        ph(8'hC0, 24'h00_0300, 24'h00_0100, 24'h00_0100, 1'b1);
        apb(1'b0, STAT_OFFSET, '0);
        chk("status", rd, 32'h0000_0003);
        summarize();
    end
endmodule
